// ===== hw/fifo_block_irq_threshold.v
`timescale 1ns/1ns
`default_nettype none
`include "fifo_irq_map.vh"

module fifo_block_irq_threshold #(
  parameter CNT_W = 20,
  parameter DIN_N = 4
) (
  input  wire        i_clk,
  input  wire        i_srst,
  input  wire        i_fifo_wr,
  input  wire        i_sample_done,
  input  wire        i_frame_max,
  input  wire        i_trig_start,
  input  wire        i_trig_stop,
  input  wire [3:0]  i_din,
  input  wire [7:0]  i_awaddr,
  input  wire        i_awvalid,
  output reg         o_awready,
  input  wire [31:0] i_wdata,
  input  wire [3:0]  i_wstrb,
  input  wire        i_wvalid,
  output reg         o_wready,
  output reg  [1:0]  o_bresp,
  output reg         o_bvalid,
  input  wire        i_bready,
  input  wire [7:0]  i_araddr,
  input  wire        i_arvalid,
  output reg         o_arready,
  output reg  [31:0] o_rdata,
  output reg  [1:0]  o_rresp,
  output reg         o_rvalid,
  input  wire        i_rready,
  output reg         o_irq,
  output reg         o_thresh_pulse,
  output reg         o_adc_sample_start,
  output reg         o_adc_burst_start
);

  // configuration and state registers
  reg [`CFG_WIDTH-1:0] config_reg;
  reg [31:0]           event_threshold_count_reg;
  reg [31:0]           thr_cnt_reg;
  reg                  thr_done_reg;
  reg [CNT_W-1:0]      fifo_cnt_reg;
  reg [7:0]            blk_cnt_reg;
  reg [`ST_WIDTH-1:0]  status_reg;
  reg [`ST_WIDTH-1:0]  enable_reg;

  // bus state
  reg                  aw_got_reg;
  reg                  w_got_reg;
  reg [7:0]            waddr_reg;
  reg [31:0]           wdata_reg;
  reg [3:0]            wstrb_reg;

  // input synchronisers
  reg [DIN_N-1:0]      din_meta_reg;
  reg [DIN_N-1:0]      din_sync_reg;
  reg [DIN_N-1:0]      din_prev_reg;

  wire [3:0] fifo_irq_block_count     = config_reg[`CFG_BLK_MSB:`CFG_BLK_LSB];
  wire [3:0] threshold_counter_source = config_reg[`CFG_SRC_MSB:`CFG_SRC_LSB];
  wire       threshold_trigger_sync   = config_reg[`CFG_SYNC_BIT];
  wire       periodic_mode            = config_reg[`CFG_PERIODIC_BIT];
  wire       register_bank_select     = config_reg[`CFG_BANK_BIT];

  // --- register write decode ---
  wire       wr_do   = aw_got_reg & w_got_reg & ~o_bvalid;
  wire       wr_cfg  = wr_do & (waddr_reg == `ADDR_CONFIG);
  wire       wr_thr  = wr_do & (waddr_reg == `ADDR_THRESHOLD) & register_bank_select;
  wire       wr_clr  = wr_do & (waddr_reg == `ADDR_CLEAR);
  wire       wr_en   = wr_do & (waddr_reg == `ADDR_ENABLE);
  wire       wr_hit  = wr_cfg | wr_clr | wr_en |
                       (wr_do & (waddr_reg == `ADDR_THRESHOLD));

  // byte-lane merge for the write data
  reg [31:0] cfg_merge;
  reg [31:0] thr_merge;
  integer    b;
  always @* begin
    cfg_merge = {{(32-`CFG_WIDTH){1'b0}}, config_reg};
    thr_merge = event_threshold_count_reg;
    for (b = 0; b < 4; b = b + 1) begin
      if (wstrb_reg[b]) begin
        cfg_merge[8*b +: 8] = wdata_reg[8*b +: 8];
        thr_merge[8*b +: 8] = wdata_reg[8*b +: 8];
      end
    end
  end

  // --- digital input edge events ---
  wire [DIN_N-1:0] din_rise;
  wire [DIN_N-1:0] din_fall;
  genvar g;
  generate
    for (g = 0; g < DIN_N; g = g + 1) begin : g_din
      assign din_rise[g] = din_sync_reg[g] & ~din_prev_reg[g];
      assign din_fall[g] = ~din_sync_reg[g] & din_prev_reg[g];
    end
  endgenerate

  // --- fifo block-count interrupt ---
  reg [CNT_W-1:0] fifo_target;
  always @* begin
    if (fifo_irq_block_count <= `BLK_LAST_DOUBLING) begin
      fifo_target = `BLK_BASE_SAMPLES << fifo_irq_block_count;
    end else begin
      fifo_target = `BLK_FRACT_SAMPLES <<
                    (fifo_irq_block_count - `BLK_FRACT_FIRST);
    end
  end

  wire [CNT_W-1:0] fifo_cnt_inc = fifo_cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
  wire             fifo_event   = i_fifo_wr & (fifo_cnt_inc >= fifo_target);
  wire             block_event  = i_fifo_wr & (blk_cnt_reg == `BLK_SAMPLES_LAST);

  // --- threshold counter source select ---
  reg [15:0] src_events;
  always @* begin
    src_events      = 16'h0000;
    src_events[1]   = i_sample_done;
    src_events[2]   = block_event;
    src_events[3]   = i_frame_max;
    src_events[4]   = i_trig_start;
    src_events[5]   = i_trig_stop;
    src_events[8]   = din_rise[0];
    src_events[9]   = din_fall[0];
    src_events[10]  = din_rise[1];
    src_events[11]  = din_fall[1];
    src_events[12]  = din_rise[2];
    src_events[13]  = din_fall[2];
    src_events[14]  = din_rise[3];
    src_events[15]  = din_fall[3];
  end
  wire count_event = src_events[threshold_counter_source];

  // --- threshold counter ---
  wire        thr_zero   = (event_threshold_count_reg == 32'h00000000);
  wire [31:0] thr_minus1 = event_threshold_count_reg - 32'h00000001;
  wire [31:0] thr_inc    = thr_cnt_reg + 32'h00000001;
  reg  [31:0] thr_cnt_next;
  reg         thr_done_next;
  reg         thr_fire;
  always @* begin
    thr_cnt_next  = thr_cnt_reg;
    thr_done_next = thr_done_reg;
    thr_fire      = 1'b0;
    if (threshold_trigger_sync & i_trig_start) begin
      thr_cnt_next  = 32'h00000000;
      thr_done_next = 1'b0;
    end else if (wr_thr) begin
      thr_cnt_next  = 32'h00000000;
      thr_done_next = 1'b0;
    end else if (count_event & ~thr_zero & ~thr_done_reg) begin
      if (periodic_mode) begin
        if (thr_cnt_reg == event_threshold_count_reg) begin
          thr_fire     = 1'b1;
          thr_cnt_next = 32'h00000000;
        end else begin
          thr_cnt_next = thr_inc;
        end
      end else begin
        thr_cnt_next = thr_inc;
        if (thr_cnt_reg == thr_minus1) begin
          thr_fire      = 1'b1;
          thr_done_next = 1'b1;
        end
      end
    end
  end

  // --- status: set wins over clear ---
  reg [`ST_WIDTH-1:0] status_set;
  reg [`ST_WIDTH-1:0] status_next;
  always @* begin
    status_set                 = {`ST_WIDTH{1'b0}};
    status_set[`ST_FIFO_BIT]   = fifo_event;
    status_set[`ST_THRESH_BIT] = thr_fire;
    status_next                = status_reg;
    if (wr_clr) begin
      status_next = status_reg & ~wdata_reg[`ST_WIDTH-1:0];
    end
    status_next = status_next | status_set;
  end

  // --- read mux ---
  reg [31:0] rd_data;
  reg        rd_hit;
  always @* begin
    rd_data = 32'h00000000;
    rd_hit  = 1'b1;
    case (i_araddr)
      `ADDR_CONFIG: begin
        rd_data[`CFG_WIDTH-1:0] = config_reg;
      end
      `ADDR_THRESHOLD: begin
        if (register_bank_select) begin
          rd_data = event_threshold_count_reg;
        end
      end
      `ADDR_COUNT: begin
        rd_data = thr_cnt_reg;
      end
      `ADDR_STATUS: begin
        rd_data[`ST_WIDTH-1:0] = status_reg;
      end
      `ADDR_CLEAR: begin
        rd_data = 32'h00000000;
      end
      `ADDR_ENABLE: begin
        rd_data[`ST_WIDTH-1:0] = enable_reg;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  // --- clocked logic ---
  always @(posedge i_clk) begin
    if (i_srst) begin
      config_reg                <= `CONFIG_RESET;
      event_threshold_count_reg <= `THRESHOLD_RESET;
      thr_cnt_reg               <= 32'h00000000;
      thr_done_reg              <= 1'b0;
      fifo_cnt_reg              <= {CNT_W{1'b0}};
      blk_cnt_reg               <= 8'h00;
      status_reg                <= {`ST_WIDTH{1'b0}};
      enable_reg                <= `ENABLE_RESET;
      aw_got_reg                <= 1'b0;
      w_got_reg                 <= 1'b0;
      waddr_reg                 <= 8'h00;
      wdata_reg                 <= 32'h00000000;
      wstrb_reg                 <= 4'h0;
      din_meta_reg              <= {DIN_N{1'b0}};
      din_sync_reg              <= {DIN_N{1'b0}};
      din_prev_reg              <= {DIN_N{1'b0}};
      o_awready                 <= 1'b1;
      o_wready                  <= 1'b1;
      o_bvalid                  <= 1'b0;
      o_bresp                   <= `RESP_OKAY;
      o_arready                 <= 1'b1;
      o_rvalid                  <= 1'b0;
      o_rresp                   <= `RESP_OKAY;
      o_rdata                   <= 32'h00000000;
      o_irq                     <= 1'b0;
      o_thresh_pulse            <= 1'b0;
      o_adc_sample_start        <= 1'b0;
      o_adc_burst_start         <= 1'b0;
    end else begin
      din_meta_reg <= i_din;
      din_sync_reg <= din_meta_reg;
      din_prev_reg <= din_sync_reg;

      // write address and data, taken in either order
      if (i_awvalid & o_awready) begin
        aw_got_reg <= 1'b1;
        waddr_reg  <= i_awaddr;
        o_awready  <= 1'b0;
      end
      if (i_wvalid & o_wready) begin
        w_got_reg <= 1'b1;
        wdata_reg <= i_wdata;
        wstrb_reg <= i_wstrb;
        o_wready  <= 1'b0;
      end
      if (wr_do) begin
        o_bvalid <= 1'b1;
        o_bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (o_bvalid & i_bready) begin
        o_bvalid   <= 1'b0;
        aw_got_reg <= 1'b0;
        w_got_reg  <= 1'b0;
        o_awready  <= 1'b1;
        o_wready   <= 1'b1;
      end
      if (wr_cfg) begin
        config_reg <= cfg_merge[`CFG_WIDTH-1:0];
      end
      if (wr_thr) begin
        event_threshold_count_reg <= thr_merge;
      end
      if (wr_en) begin
        enable_reg <= wdata_reg[`ST_WIDTH-1:0];
      end

      // read channel
      if (i_arvalid & o_arready) begin
        o_arready <= 1'b0;
        o_rvalid  <= 1'b1;
        o_rdata   <= rd_data;
        o_rresp   <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (o_rvalid & i_rready) begin
        o_rvalid  <= 1'b0;
        o_arready <= 1'b1;
      end

      // sample counters
      if (i_fifo_wr) begin
        blk_cnt_reg  <= blk_cnt_reg + 8'h01;
        fifo_cnt_reg <= fifo_event ? {CNT_W{1'b0}} : fifo_cnt_inc;
      end

      thr_cnt_reg  <= thr_cnt_next;
      thr_done_reg <= thr_done_next;
      status_reg   <= status_next;

      // threshold output routing and interrupt output
      o_thresh_pulse     <= thr_fire;
      o_adc_sample_start <= thr_fire & config_reg[`CFG_ADC_SAMPLE_BIT];
      o_adc_burst_start  <= thr_fire & config_reg[`CFG_ADC_BURST_BIT];
      o_irq              <= |(status_next & enable_reg);
    end
  end

endmodule

`default_nettype wire

// ===== hw/fifo_irq_map.vh
`ifndef FIFO_IRQ_MAP_VH
`define FIFO_IRQ_MAP_VH

// register byte addresses
`define ADDR_CONFIG        8'h00
`define ADDR_THRESHOLD     8'h08
`define ADDR_COUNT         8'h0c
`define ADDR_STATUS        8'h10
`define ADDR_CLEAR         8'h14
`define ADDR_ENABLE        8'h18

// config field positions
`define CFG_BLK_LSB        0
`define CFG_BLK_MSB        3
`define CFG_SRC_LSB        8
`define CFG_SRC_MSB        11
`define CFG_SYNC_BIT       12
`define CFG_PERIODIC_BIT   13
`define CFG_ADC_SAMPLE_BIT 14
`define CFG_ADC_BURST_BIT  15
`define CFG_BANK_BIT       16
`define CFG_WIDTH          17

// status / clear / enable bit positions
`define ST_FIFO_BIT        0
`define ST_THRESH_BIT      1
`define ST_WIDTH           2

// reset values
`define CONFIG_RESET       17'h00000
`define THRESHOLD_RESET    32'h00000000
`define ENABLE_RESET       2'h0

// fifo interrupt sizing
`define BLK_LAST_DOUBLING  4'ha
`define BLK_FRACT_FIRST    4'hb
`define BLK_BASE_SAMPLES   20'h00200
`define BLK_FRACT_SAMPLES  20'h00010
`define BLK_SAMPLES_LAST   8'hff

// axi responses
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// ===== testbench/fifo_block_irq_threshold_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module fifo_block_irq_threshold_monitor (
  input wire        i_clk,
  input wire        i_srst,
  input wire        i_awvalid,
  input wire        o_awready,
  input wire        i_wvalid,
  input wire        o_wready,
  input wire        o_bvalid,
  input wire [7:0]  i_araddr,
  input wire        i_arvalid,
  input wire        o_arready,
  input wire [31:0] o_rdata,
  input wire [1:0]  o_rresp,
  input wire        o_rvalid,
  input wire        o_irq,
  input wire        o_thresh_pulse,
  input wire        o_adc_sample_start,
  input wire        o_adc_burst_start
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  sequence s_wr_taken;
    i_awvalid && o_awready && i_wvalid && o_wready;
  endsequence
  sequence s_rd_taken;
    i_arvalid && o_arready;
  endsequence
  a_write_answer: assert property (s_wr_taken |-> ##2 o_bvalid)
    else $error("write response missing");
  a_write_block: assert property (o_bvalid |-> !o_awready && !o_wready)
    else $error("write taken while response pending");
  a_read_answer: assert property (s_rd_taken |=> o_rvalid)
    else $error("read response missing");
  a_read_block: assert property (o_rvalid |-> !o_arready)
    else $error("read taken while response pending");
  a_unmapped_read: assert property (s_rd_taken ##0 i_araddr == 8'h04 |=> o_rresp == 2'h2 && o_rdata == 32'h0)
    else $error("unmapped read not refused");
  a_sample_route: assert property (o_adc_sample_start |-> o_thresh_pulse)
    else $error("sample start without threshold pulse");
  a_burst_route: assert property (o_adc_burst_start |-> o_thresh_pulse)
    else $error("burst start without threshold pulse");
  a_reset_idle: assert property ($fell(i_srst) |-> o_awready && o_arready && !o_irq && !o_thresh_pulse)
    else $error("outputs not idle after reset");
endmodule
bind fifo_block_irq_threshold fifo_block_irq_threshold_monitor i_fifo_block_irq_threshold_monitor (.*);
`default_nettype wire

// ===== testbench/fifo_block_irq_threshold_bench.sv
`timescale 1ns/1ns
`default_nettype none
module fifo_block_irq_threshold_bench;
  logic        i_clk = 1'b0, i_srst = 1'b1, i_fifo_wr = 1'b0, i_sample_done = 1'b0;
  logic        i_frame_max = 1'b0, i_trig_start = 1'b0, i_trig_stop = 1'b0, i_bready = 1'b0;
  logic        i_awvalid = 1'b0, i_wvalid = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
  logic [3:0]  i_din = 4'h0, i_wstrb = 4'h0;
  logic [7:0]  i_awaddr = 8'h00, i_araddr = 8'h00;
  logic [31:0] i_wdata = 32'h0, rv;
  logic [1:0]  rr;
  wire         o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq;
  wire         o_thresh_pulse, o_adc_sample_start, o_adc_burst_start;
  wire  [1:0]  o_bresp, o_rresp;
  wire  [31:0] o_rdata;
  int          fail_count = 0, num_checks = 0, np = 0, ns = 0, nb = 0, s, e;
  int          codes[7] = '{0, 1, 11, 12, 13, 14, 15};
  fifo_block_irq_threshold i_fifo_block_irq_threshold (.*);
  initial forever #50 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    if (!i_srst) begin
      np <= np + o_thresh_pulse;
      ns <= ns + o_adc_sample_start;
      nb <= nb + o_adc_burst_start;
    end
  end
  task summarize;
    if (fail_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] x, input logic [31:0] g);
    num_checks++;
    if (g !== x) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, x, g);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st = 4'hf);
    logic aw, w, ta, tw, tb;
    aw = 1; w = 1; tb = 0;
    @(posedge i_clk);
    i_awaddr <= a; i_wdata <= d; i_wstrb <= st;
    i_awvalid <= 1; i_wvalid <= 1; i_bready <= 1;
    while (!tb) begin
      @(negedge i_clk);
      ta = aw && o_awready; tw = w && o_wready; tb = o_bvalid; rr = o_bresp;
      @(posedge i_clk);
      if (ta) begin aw = 0; i_awvalid <= 0; end
      if (tw) begin w = 0; i_wvalid <= 0; end
    end
    i_bready <= 0;
  endtask
  task rd(input logic [7:0] a);
    logic ta, tb;
    tb = 0;
    @(posedge i_clk);
    i_araddr <= a; i_arvalid <= 1; i_rready <= 1;
    while (!tb) begin
      @(negedge i_clk);
      ta = o_arready; tb = o_rvalid; rv = o_rdata; rr = o_rresp;
      @(posedge i_clk);
      if (ta) i_arvalid <= 0;
    end
    i_rready <= 0;
  endtask
  task fifo(input int n);
    @(posedge i_clk);
    i_fifo_wr <= 1;
    repeat (n) @(posedge i_clk);
    i_fifo_wr <= 0;
    repeat (4) @(posedge i_clk);
  endtask
  task ev(input int src);
    if (src == 2) fifo(256);
    else if (src > 7) begin
      @(posedge i_clk);
      i_din[(src - 8) / 2] <= src[0];
      repeat (6) @(posedge i_clk);
      i_din[(src - 8) / 2] <= !src[0];
      repeat (6) @(posedge i_clk);
      i_din <= 4'h0;
    end else begin
      @(posedge i_clk);
      i_frame_max <= (src == 3); i_trig_start <= (src == 4);
      i_trig_stop <= (src == 5); i_sample_done <= (src < 2 || src > 5);
      @(posedge i_clk);
      {i_frame_max, i_trig_start, i_trig_stop, i_sample_done} <= 4'h0;
    end
    repeat (6) @(posedge i_clk);
  endtask
  initial begin
    repeat (20000) @(posedge i_clk);
    fail_count++;
    summarize;
  end
  initial begin
    repeat (20) @(posedge i_clk);
    i_srst <= 0;
    rd(8'h00); chk("config", 32'h0, rv);
    rd(8'h08); chk("thr_no_bank", 32'h0, rv);
    wr(8'h00, 32'h10000); rd(8'h08); chk("thr_reset", 32'h0, rv);
    wr(8'h08, 32'h11223344, 4'h1); wr(8'h08, 32'h55667788, 4'hc);
    rd(8'h08); chk("thr_lanes", 32'h55660044, rv);
    rd(8'h04); chk("unmapped_rd", 32'h2, {30'h0, rr});
    wr(8'h1c, 32'h1); chk("unmapped_wr", 32'h2, {30'h0, rr});
    wr(8'h18, 32'h3); wr(8'h14, 32'h3);
    foreach (codes[k]) begin
      wr(8'h00, 32'h10000 | codes[k]);
      fifo((codes[k] < 11 ? 512 << codes[k] : 16 << (codes[k] - 11)) - 1);
      rd(8'h10); chk("fifo_early", 32'h0, rv[0]);
      fifo(1); rd(8'h10); chk("fifo_fire", 32'h1, rv[0]);
      chk("fifo_irq", 32'h1, o_irq);
      wr(8'h14, 32'h1);
    end
    fifo(256); wr(8'h18, 32'h0);
    @(negedge i_clk);
    chk("irq_masked", 32'h0, o_irq);
    wr(8'h18, 32'h3); wr(8'h14, 32'h3);
    wr(8'h00, 32'h14100); wr(8'h08, 32'h3);
    ev(1); ev(1); chk("once_early", 32'h0, np);
    ev(1); chk("once_fire", 32'h1, np); chk("adc_sample", 32'h1, ns);
    rd(8'h10); chk("thr_status", 32'h1, rv[1]); chk("thr_irq", 32'h1, o_irq);
    repeat (4) ev(1);
    chk("once_halt", 32'h1, np);
    wr(8'h00, 32'h1a100); wr(8'h08, 32'h3);
    for (s = 1; s <= 8; s++) begin
      ev(1); chk("periodic", 1 + s / 4, np);
    end
    chk("adc_burst", 32'h2, nb);
    wr(8'h08, 32'h0); repeat (5) ev(1);
    chk("zero_thr", 32'h3, np);
    wr(8'h00, 32'h11100); wr(8'h08, 32'h2);
    ev(1); ev(4); ev(1); chk("sync_clear", 32'h3, np);
    rd(8'h0c); chk("sync_count", 32'h1, rv);
    ev(1); chk("sync_fire", 32'h4, np);
    e = 4;
    for (s = 0; s < 16; s++) begin
      wr(8'h00, 32'h10000 | (s << 8)); wr(8'h08, 32'h1);
      ev(s);
      e = e + (s != 0 && s != 6 && s != 7);
      chk("source", e, np);
    end
    summarize;
  end
endmodule
`default_nettype wire
